// *** bus_event_qualifier.sv ***
// Bus-unit event qualifier with its event counter and Wishbone registers
//
// What this block does
// [R1] Mask in bits 24:9; bits 0-2 L2 hits
// [R2] Bits 3-5 select L3 read hits S/E/M
// [R3] Bit 8 L2 read miss, bit 9 L3
// [R4] Bit 10 writeback lookup missing L2
// [R5] Loads and RFOs both count as reads
// [R6] Use transaction status as currently held
// [R7] One count per matching queue allocation
// [R8] Sector or chunk allocation counts alike
// [R9] Each retry counts again
// [R10] Mask fields independent; all but source and bit 15 ORed together
// [R11] Request-type bits 0-4 ORed with 5, 6
// [R12] Bits 7-8 select target memory type
// [R13] Bits 13-14 select source agent
// [R14] Bit 15 affects reads only
// [R15] (type|b5|b6|memtype) AND source agent
// [R16] Qualifying event adds exactly one when enabled and no count write lands
module bus_event_qualifier
   import ev_qual_pkg::*;
#(
   parameter int CNT_W = 32
)
(
   input wire logic clk_i,               // Core clock, 20 MHz
   input wire logic rst_i,               // Synchronous reset, active high
   input wire logic wb_cyc_i,            // Wishbone cycle
   input wire logic wb_stb_i,            // Wishbone strobe
   input wire logic wb_we_i,             // Wishbone write
   input wire logic [ADDR_W-1:0] wb_adr_i, // Byte address
   input wire logic [3:0] wb_sel_i,      // Byte enables
   input wire logic [DATA_W-1:0] wb_dat_i, // Write data
   output logic [DATA_W-1:0] wb_dat_o,   // Read data
   output logic wb_ack_o,                // Acknowledge
   input wire logic ref_valid_i,         // Cache lookup reported
   input wire logic is_load_i,           // Lookup is a load
   input wire logic is_rfo_i,            // Lookup is an RFO
   input wire logic is_wb_i,             // Lookup is a writeback
   input wire logic l2_hit_i,            // L2 hit now
   input wire logic l3_hit_i,            // L3 hit now
   input wire line_state_t state_i,      // Line state on hit
   input wire logic alloc_i,             // Queue entry allocated
   input wire logic [4:0] req_type_i,    // Request type code
   input wire logic is_read_i,           // Queue entry is a read
   input wire logic is_write_i,          // Queue entry is a write
   input wire logic is_prefetch_i,       // Read began as prefetch
   input wire logic mem_uc_i,            // Uncacheable target
   input wire logic mem_wc_i,            // Write-combining target
   input wire logic src_own_i,           // Own processor is source
   output logic event_o,                 // One-cycle pulse per qualified event, also when a count write wins
   output logic [CNT_W-1:0] count_o      // Counter value
);
   generate
      if (CNT_W < 8 || CNT_W > DATA_W)
      begin : g_bad_width
         $error("CNT_W must be 8 to 32");
      end
   endgenerate

   ev_qual_if qi();

   logic [DATA_W-1:0] evsel_ff;
   logic [DATA_W-1:0] cfg_ff;
   logic [CNT_W-1:0] count_ff;
   logic [1:0] last_match_ff;
   logic event_ff;
   logic ack_ff;
   logic [DATA_W-1:0] rdat_ff;
   logic [6:0] sel_code;
   logic count_en;
   logic hit;
   logic req;
   logic wr_strobe;
   logic [DATA_W-1:0] nxt_rdat;

   function automatic logic [DATA_W-1:0] byte_merge(input logic [DATA_W-1:0] old,
                                                    input logic [DATA_W-1:0] din,
                                                    input logic [3:0] sel);
      logic [DATA_W-1:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
         begin
            r[b*8 +: 8] = din[b*8 +: 8];
         end
      end
      byte_merge = r;
   endfunction

   assign qi.mask = evsel_ff[MASK_MSB:MASK_LSB]; // see [R1]
   assign sel_code = evsel_ff[SEL_MSB:SEL_LSB];
   assign count_en = cfg_ff[CFG_EN_BIT];

   cache_ref_qual u_cache (
      .q(qi.cache),
      .ref_valid_i(ref_valid_i),
      .is_load_i(is_load_i),
      .is_rfo_i(is_rfo_i),
      .is_wb_i(is_wb_i),
      .l2_hit_i(l2_hit_i),
      .l3_hit_i(l3_hit_i),
      .state_i(state_i)
   );

   bus_queue_qual u_queue (
      .q(qi.queue),
      .alloc_i(alloc_i),
      .req_type_i(req_type_i),
      .is_read_i(is_read_i),
      .is_write_i(is_write_i),
      .is_prefetch_i(is_prefetch_i),
      .mem_uc_i(mem_uc_i),
      .mem_wc_i(mem_wc_i),
      .src_own_i(src_own_i)
   );

   // Only the event picked by the select code may reach the counter
   always_comb
   begin
      hit = 1'b0;
      if (sel_code == SEL_CACHE_REF)
      begin
         hit = qi.cache_match;
      end
      else if (sel_code == SEL_QUEUE_ALLOC)
      begin
         hit = qi.queue_match; // see [R7]
      end
   end

   // Classic single-cycle slave: ack one cycle after strobe, then drop
   assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
   // Write lands on the edge where the master samples ack, not when taken
   assign wr_strobe = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_ff <= 1'b0;
      end
      else
      begin
         ack_ff <= req;
      end
   end

   always_comb
   begin
      nxt_rdat = '0;
      unique case (wb_adr_i)
         EVSEL_OFS: nxt_rdat = evsel_ff;
         CFG_OFS: nxt_rdat = cfg_ff;
         COUNT_OFS: nxt_rdat = DATA_W'(count_ff);
         STATUS_OFS: nxt_rdat = {30'h0, last_match_ff};
         default: nxt_rdat = '0;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rdat_ff <= '0;
      end
      else if (req && !wb_we_i)
      begin
         rdat_ff <= nxt_rdat;
      end
   end

   // Lane enables merge into the held value; other bytes keep their state
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         evsel_ff <= EVSEL_RST;
      end
      else if (wr_strobe && wb_adr_i == EVSEL_OFS)
      begin
         evsel_ff <= byte_merge(evsel_ff, wb_dat_i, wb_sel_i);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cfg_ff <= CFG_RST;
      end
      else if (wr_strobe && wb_adr_i == CFG_OFS)
      begin
         cfg_ff <= byte_merge(cfg_ff, wb_dat_i, wb_sel_i);
      end
   end

   // Software write beats a same-cycle event: the preset value is kept exact
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         count_ff <= '0;
      end
      else if (wr_strobe && wb_adr_i == COUNT_OFS)
      begin
         count_ff <= CNT_W'(byte_merge(DATA_W'(count_ff), wb_dat_i, wb_sel_i));
      end
      else if (count_en && hit)
      begin
         count_ff <= count_ff + 1'b1; // see [R16] see [R8] see [R9]
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         event_ff <= 1'b0;
         last_match_ff <= 2'h0;
      end
      else
      begin
         event_ff <= count_en & hit; // see [R16]
         last_match_ff <= {qi.queue_match, qi.cache_match};
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdat_ff;
   assign event_o = event_ff;
   assign count_o = count_ff;

   // Helper: software counter write at this edge
   logic cnt_wr;
   assign cnt_wr = wr_strobe && wb_adr_i == COUNT_OFS;

   a_count_step: assert property (@(posedge clk_i) disable iff (rst_i) // see [R16]
      (count_en && hit && !cnt_wr) |=> (count_ff == $past(count_ff) + 1'b1))
      else $error("counter did not step by one on a qualified event");

   a_count_hold: assert property (@(posedge clk_i) disable iff (rst_i) // see [R16]
      (!(count_en && hit) && !cnt_wr) |=> $stable(count_ff))
      else $error("counter moved without a qualified event");

   a_pulse_tracks: assert property (@(posedge clk_i) disable iff (rst_i) // see [R7]
      event_o |-> ($past(alloc_i) || $past(ref_valid_i)) && $past(count_en))
      else $error("event pulse without a source");

   a_l2_hit_sel: assert property (@(posedge clk_i) disable iff (rst_i) // see [R1]
      (ref_valid_i && is_load_i && l2_hit_i && state_i == LINE_MODIFIED
       && qi.mask[C_L2_HIT_LSB + 2]) |-> qi.cache_match)
      else $error("modified L2 read hit not matched");

   a_l3_hit_sel: assert property (@(posedge clk_i) disable iff (rst_i) // see [R2] see [R5]
      (ref_valid_i && is_rfo_i && l3_hit_i && state_i == LINE_SHARED
       && qi.mask[C_L3_HIT_LSB]) |-> qi.cache_match)
      else $error("shared L3 RFO hit not matched");

   a_miss_sel: assert property (@(posedge clk_i) disable iff (rst_i) // see [R3]
      (ref_valid_i && is_load_i && !l3_hit_i && qi.mask[C_L3_MISS]) |-> qi.cache_match)
      else $error("L3 read miss not matched");

   a_wb_miss: assert property (@(posedge clk_i) disable iff (rst_i) // see [R4]
      (ref_valid_i && is_wb_i && !l2_hit_i && qi.mask[C_L2_WB_MISS]) |-> qi.cache_match)
      else $error("writeback L2 miss not matched");

   a_no_ref_no_match: assert property (@(posedge clk_i) disable iff (rst_i) // see [R6]
      !ref_valid_i |-> !qi.cache_match)
      else $error("cache match without a lookup");

   a_src_gate: assert property (@(posedge clk_i) disable iff (rst_i) // see [R13] see [R15]
      (src_own_i && !qi.mask[Q_SRC_OWN]) |-> !qi.queue_match)
      else $error("queue match with wrong source agent");

   a_all_read: assert property (@(posedge clk_i) disable iff (rst_i) // see [R11] see [R14]
      (alloc_i && is_read_i && !is_prefetch_i && qi.mask[Q_ALL_READ] && src_own_i
       && qi.mask[Q_SRC_OWN]) |-> qi.queue_match)
      else $error("own demand read not matched");

   a_mem_type: assert property (@(posedge clk_i) disable iff (rst_i) // see [R12]
      (alloc_i && mem_wc_i && qi.mask[Q_MEM_WC] && !src_own_i
       && qi.mask[Q_SRC_OTHER] && !(is_read_i && is_prefetch_i && qi.mask[Q_READ_DEMAND]))
       |-> qi.queue_match)
      else $error("write-combining entry not matched");

   a_retry_twice: assert property (@(posedge clk_i) disable iff (rst_i) // see [R9]
      (sel_code == SEL_QUEUE_ALLOC && count_en && qi.queue_match && !cnt_wr)
      ##1 (count_en && qi.queue_match && sel_code == SEL_QUEUE_ALLOC && !cnt_wr)
      |=> (count_ff == $past(count_ff, 2) + 2'd2))
      else $error("back-to-back allocations not both counted");

   a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held for more than one cycle");

   a_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("request taken but not acked next cycle");

   a_event_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // see [R16]
      (count_en && hit) |=> event_o)
      else $error("qualified event gave no pulse");

   a_sel_gate: assert property (@(posedge clk_i) disable iff (rst_i) // see [R7]
      (sel_code != SEL_CACHE_REF && sel_code != SEL_QUEUE_ALLOC) |-> !hit)
      else $error("unselected event reached the counter");
endmodule

// *** ev_qual_pkg.sv ***
// Constants shared by the bus-unit event qualifier
package ev_qual_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int MASK_W = 16;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] EVSEL_OFS = 4'h0;
   localparam logic [ADDR_W-1:0] CFG_OFS = 4'h4;
   localparam logic [ADDR_W-1:0] COUNT_OFS = 4'h8;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 4'hc;

   // Event select register layout
   localparam int MASK_LSB = 9;
   localparam int MASK_MSB = 24;
   localparam int SEL_LSB = 25;
   localparam int SEL_MSB = 31;
   localparam logic [6:0] SEL_CACHE_REF = 7'h0c;
   localparam logic [6:0] SEL_QUEUE_ALLOC = 7'h03;

   // Counter configuration register
   localparam int CFG_EN_BIT = 12;
   localparam logic [DATA_W-1:0] EVSEL_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] CFG_RST = 32'h0000_0000;

   // Cache-reference mask bits
   localparam int C_L2_HIT_LSB = 0;
   localparam int C_L3_HIT_LSB = 3;
   localparam int C_L2_MISS = 8;
   localparam int C_L3_MISS = 9;
   localparam int C_L2_WB_MISS = 10;

   // Queue-allocation mask bits
   localparam int Q_REQ_LSB = 0;
   localparam int Q_REQ_MSB = 4;
   localparam int Q_ALL_READ = 5;
   localparam int Q_ALL_WRITE = 6;
   localparam int Q_MEM_UC = 7;
   localparam int Q_MEM_WC = 8;
   localparam int Q_SRC_OWN = 13;
   localparam int Q_SRC_OTHER = 14;
   localparam int Q_READ_DEMAND = 15;

   // Line state code on the cache-reference inputs
   typedef enum logic [1:0] {
      LINE_SHARED = 2'b00,
      LINE_EXCLUSIVE = 2'b01,
      LINE_MODIFIED = 2'b10,
      LINE_INVALID = 2'b11
   } line_state_t;
endpackage

// *** ev_qual_if.sv ***
// Mask and match signals between the top and its two qualifiers
interface ev_qual_if;
   import ev_qual_pkg::*;
   logic [MASK_W-1:0] mask;
   logic cache_match;
   logic queue_match;
   modport ctl (output mask, input cache_match, input queue_match);
   modport cache (input mask, output cache_match);
   modport queue (input mask, output queue_match);
endinterface

// *** cache_ref_qual.sv ***
// Mask match for the cache-reference event
module cache_ref_qual
   import ev_qual_pkg::*;
(
   ev_qual_if.cache q,                   // Mask in, match out
   input wire logic ref_valid_i,         // Lookup reported this cycle
   input wire logic is_load_i,           // Ordinary load
   input wire logic is_rfo_i,            // Read for ownership
   input wire logic is_wb_i,             // Writeback lookup from data path
   input wire logic l2_hit_i,            // Current L2 hit status
   input wire logic l3_hit_i,            // Current L3 hit status
   input wire line_state_t state_i       // Current line state on hit
);
   logic rd;
   logic [2:0] st;
   logic [1:0] lvl_hit;
   logic [1:0] lvl_any;

   function automatic logic [2:0] state_onehot(input line_state_t s);
      unique case (s)
         LINE_SHARED: state_onehot = 3'h1;
         LINE_EXCLUSIVE: state_onehot = 3'h2;
         LINE_MODIFIED: state_onehot = 3'h4;
         LINE_INVALID: state_onehot = 3'h0;
      endcase
   endfunction

   assign rd = is_load_i | is_rfo_i; // see [R5]
   assign st = state_onehot(state_i);
   assign lvl_hit = {l3_hit_i, l2_hit_i};

   // Status is taken as it stands in the reporting cycle, never latched
   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_lvl
         localparam int LSB = (g == 0) ? C_L2_HIT_LSB : C_L3_HIT_LSB;
         assign lvl_any[g] = lvl_hit[g] & |(q.mask[LSB +: 3] & st); // see [R1] see [R2] see [R6]
      end
   endgenerate

   always_comb
   begin
      q.cache_match = 1'b0;
      if (ref_valid_i)
      begin
         q.cache_match = (rd & |lvl_any)
            | (rd & ~l2_hit_i & q.mask[C_L2_MISS])       // see [R3]
            | (rd & ~l3_hit_i & q.mask[C_L3_MISS])       // see [R3]
            | (is_wb_i & ~l2_hit_i & q.mask[C_L2_WB_MISS]); // see [R4]
      end
   end
endmodule

// *** bus_queue_qual.sv ***
// Mask match for the bus queue allocation event
module bus_queue_qual
   import ev_qual_pkg::*;
(
   ev_qual_if.queue q,                   // Mask in, match out
   input wire logic alloc_i,             // Entry allocated this cycle
   input wire logic [4:0] req_type_i,    // Bus request type code
   input wire logic is_read_i,           // Read transaction
   input wire logic is_write_i,          // Write transaction
   input wire logic is_prefetch_i,       // Read issued as prefetch
   input wire logic mem_uc_i,            // Target is uncacheable
   input wire logic mem_wc_i,            // Target is write-combining
   input wire logic src_own_i            // Issued by this processor
);
   logic req_m;
   logic mem_m;
   logic src_m;
   logic read_ok;

   // A field value is the bits set in it; an empty field never matches
   assign req_m = (q.mask[Q_REQ_MSB:Q_REQ_LSB] != 5'h00)
      && (req_type_i == q.mask[Q_REQ_MSB:Q_REQ_LSB]); // see [R10] see [R11]
   assign mem_m = (q.mask[Q_MEM_UC] & mem_uc_i) | (q.mask[Q_MEM_WC] & mem_wc_i); // see [R12]
   assign src_m = (q.mask[Q_SRC_OWN] & src_own_i)
      | (q.mask[Q_SRC_OTHER] & ~src_own_i); // see [R13]
   // Demand-only filter touches reads alone
   assign read_ok = ~(is_read_i & is_prefetch_i & q.mask[Q_READ_DEMAND]); // see [R14]

   // Size of the entry plays no part; retries arrive as fresh allocations
   assign q.queue_match = alloc_i & read_ok & src_m
      & (req_m | (q.mask[Q_ALL_READ] & is_read_i)
         | (q.mask[Q_ALL_WRITE] & is_write_i) | mem_m); // see [R7] see [R8] see [R9] see [R15]
endmodule

// *** tb.sv ***
// Self-checking bench for the bus-unit event qualifier
module tb
   import ev_qual_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [ADDR_W-1:0] wb_adr_i = 4'h0;
   logic [3:0] wb_sel_i = 4'h0;
   logic [DATA_W-1:0] wb_dat_i = 32'h0;
   logic [DATA_W-1:0] wb_dat_o;
   logic wb_ack_o;
   logic ref_valid_i = 1'b0;
   logic is_load_i = 1'b0;
   logic is_rfo_i = 1'b0;
   logic is_wb_i = 1'b0;
   logic l2_hit_i = 1'b0;
   logic l3_hit_i = 1'b0;
   line_state_t state_i = LINE_INVALID;
   logic alloc_i = 1'b0;
   logic [4:0] req_type_i = 5'h0;
   logic is_read_i = 1'b0;
   logic is_write_i = 1'b0;
   logic is_prefetch_i = 1'b0;
   logic mem_uc_i = 1'b0;
   logic mem_wc_i = 1'b0;
   logic src_own_i = 1'b0;
   logic event_o;
   logic [31:0] count_o;
   int err_total = 0;
   int tests_run = 0;
   int cyc_cnt = 0;
   logic [31:0] exp_cnt = 32'h0;
   logic [31:0] rdat;
   logic [3:0] sel_v = 4'hf;

   bus_event_qualifier #(.CNT_W(32)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .ref_valid_i(ref_valid_i), .is_load_i(is_load_i), .is_rfo_i(is_rfo_i),
      .is_wb_i(is_wb_i), .l2_hit_i(l2_hit_i), .l3_hit_i(l3_hit_i), .state_i(state_i),
      .alloc_i(alloc_i), .req_type_i(req_type_i), .is_read_i(is_read_i),
      .is_write_i(is_write_i), .is_prefetch_i(is_prefetch_i), .mem_uc_i(mem_uc_i),
      .mem_wc_i(mem_wc_i), .src_own_i(src_own_i), .event_o(event_o), .count_o(count_o));

   always #25 clk_i = ~clk_i;

   task automatic close_out();
      $display("Checks %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
      begin
         $display("STATUS OK");
      end
      else
      begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Hang guard, far above the few hundred cycles the sequence needs
   always @(posedge clk_i)
   begin
      cyc_cnt++;
      if (cyc_cnt == 5000)
      begin
         err_total++;
         close_out();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // One classic cycle; data is taken at the edge that sees ack
   task automatic bus(input logic we, input logic [ADDR_W-1:0] adr, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel_v;
      wb_dat_i <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1)
         @(posedge clk_i);
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask

   task automatic rd_chk(input logic [ADDR_W-1:0] adr, input logic [31:0] exp);
      bus(1'b0, adr, 32'h0);
      chk(rdat, exp, "register read");
   endtask

   // Strobe the event input for n cycles, then check pulse and count
   task automatic run_ev(input logic isq, input logic exp, input int n);
      @(posedge clk_i);
      alloc_i <= isq;
      ref_valid_i <= ~isq;
      repeat (n) @(posedge clk_i);
      alloc_i <= 1'b0;
      ref_valid_i <= 1'b0;
      #1;
      chk({31'h0, event_o}, {31'h0, exp}, "event pulse");
      if (exp)
         exp_cnt = exp_cnt + n;
      chk(count_o, exp_cnt, "counter");
   endtask

   // Attributes: load, rfo, writeback, l2 hit, l3 hit, line state
   task automatic c_case(input logic [15:0] m, input logic [6:0] a, input logic exp);
      bus(1'b1, EVSEL_OFS, {SEL_CACHE_REF, m, 9'h0});
      {is_load_i, is_rfo_i, is_wb_i, l2_hit_i, l3_hit_i} <= a[6:2];
      state_i <= line_state_t'(a[1:0]);
      run_ev(1'b0, exp, 1);
   endtask

   // Attributes: type code, read, write, prefetch, uc, wc, own source
   task automatic q_case(input logic [15:0] m, input logic [10:0] a, input logic exp,
                         input int n);
      bus(1'b1, EVSEL_OFS, {SEL_QUEUE_ALLOC, m, 9'h0});
      {req_type_i, is_read_i, is_write_i, is_prefetch_i} <= a[10:3];
      {mem_uc_i, mem_wc_i, src_own_i} <= a[2:0];
      run_ev(1'b1, exp, n);
   endtask

   initial
   begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(EVSEL_OFS, EVSEL_RST);
      rd_chk(CFG_OFS, CFG_RST);
      rd_chk(COUNT_OFS, 32'h0);
      rd_chk(4'h6, 32'h0);
      bus(1'b1, 4'h6, 32'hffff_ffff);
      bus(1'b1, CFG_OFS, 32'h0000_1000);
      rd_chk(CFG_OFS, 32'h0000_1000);
      // Lane enables: only the low byte may change
      sel_v = 4'h1;
      bus(1'b1, CFG_OFS, 32'hffff_ffff);
      sel_v = 4'hf;
      rd_chk(CFG_OFS, 32'h0000_10ff);
      c_case(16'h0001, 7'b10010_00, 1'b1);
      c_case(16'h0001, 7'b01010_01, 1'b0);
      c_case(16'h0002, 7'b01010_01, 1'b1);
      c_case(16'h0004, 7'b10010_10, 1'b1);
      c_case(16'h0008, 7'b10001_00, 1'b1);
      c_case(16'h0010, 7'b01001_01, 1'b1);
      c_case(16'h0020, 7'b10001_10, 1'b1);
      c_case(16'h0020, 7'b10010_10, 1'b0);
      c_case(16'h0100, 7'b10000_11, 1'b1);
      c_case(16'h0100, 7'b10010_00, 1'b0);
      c_case(16'h0200, 7'b01000_11, 1'b1);
      c_case(16'h0100, 7'b00100_11, 1'b0);
      c_case(16'h0400, 7'b00100_11, 1'b1);
      c_case(16'h0400, 7'b00110_00, 1'b0);
      q_case(16'h2020, 11'b00000_100_001, 1'b1, 1);
      q_case(16'h2020, 11'b00000_100_000, 1'b0, 1);
      q_case(16'h4040, 11'b00000_010_000, 1'b1, 1);
      q_case(16'h4040, 11'b00000_010_001, 1'b0, 1);
      q_case(16'h6020, 11'b00000_100_000, 1'b1, 1);
      q_case(16'h2080, 11'b00000_000_101, 1'b1, 1);
      q_case(16'h2080, 11'b00000_000_011, 1'b0, 1);
      q_case(16'h2100, 11'b00000_000_011, 1'b1, 1);
      q_case(16'h2005, 11'b00101_000_001, 1'b1, 1);
      q_case(16'h2005, 11'b00110_000_001, 1'b0, 1);
      q_case(16'h2025, 11'b00110_100_001, 1'b1, 1);
      q_case(16'ha020, 11'b00000_101_001, 1'b0, 1);
      q_case(16'ha020, 11'b00000_100_001, 1'b1, 1);
      q_case(16'ha040, 11'b00000_011_001, 1'b1, 1);
      q_case(16'h2020, 11'b00000_100_001, 1'b1, 3);
      bus(1'b1, CFG_OFS, 32'h0);
      run_ev(1'b1, 1'b0, 1);
      // Counting off, entry still matching: status shows a queue match
      alloc_i <= 1'b1;
      rd_chk(STATUS_OFS, 32'h0000_0002);
      alloc_i <= 1'b0;
      bus(1'b1, CFG_OFS, 32'h0000_1000);
      bus(1'b1, EVSEL_OFS, {7'h01, 16'h2020, 9'h0});
      run_ev(1'b1, 1'b0, 1);
      bus(1'b1, COUNT_OFS, 32'h0000_00ff);
      exp_cnt = 32'h0000_00ff;
      rd_chk(COUNT_OFS, exp_cnt);
      rd_chk(EVSEL_OFS, {7'h01, 16'h2020, 9'h0});
      q_case(16'h2020, 11'b00000_100_001, 1'b1, 1);
      // Reset in mid-run clears the counter and the select register
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(COUNT_OFS, 32'h0);
      rd_chk(EVSEL_OFS, EVSEL_RST);
      close_out();
   end
endmodule
